//--- rtl/csa_defs.vh
// constants for the camera serial port and acquisition start block
`ifndef CSA_DEFS_VH
`define CSA_DEFS_VH
// ====================================================================
// clock and bit rates (clock 200 MHz)
`define CSA_CLK_HZ 200000000
`define CSA_OVS 16
// oversample tick divisors: clk / (rate * 16), one per rate select code
`define CSA_DIV_9K6 ((`CSA_CLK_HZ) / (9600 * `CSA_OVS))
`define CSA_DIV_19K2 ((`CSA_CLK_HZ) / (19200 * `CSA_OVS))
`define CSA_DIV_38K4 ((`CSA_CLK_HZ) / (38400 * `CSA_OVS))
`define CSA_DIV_57K6 ((`CSA_CLK_HZ) / (57600 * `CSA_OVS))
`define CSA_DIV_115K2 ((`CSA_CLK_HZ) / (115200 * `CSA_OVS))
`define CSA_DIV_230K4 ((`CSA_CLK_HZ) / (230400 * `CSA_OVS))
`define CSA_DIV_460K8 ((`CSA_CLK_HZ) / (460800 * `CSA_OVS))
`define CSA_DIV_921K6 ((`CSA_CLK_HZ) / (921600 * `CSA_OVS))
// ====================================================================
// character format
`define CSA_DATA_BITS 8
`define CSA_MID_TICK 4'h7
`define CSA_LAST_TICK 4'hF
// ====================================================================
// trigger source select codes
`define CSA_SRC_EXT 3'h0
`define CSA_TRIG_BUS_W 7
`endif

//--- rtl/csa_buf2.v
// two-entry valid/ready buffer for serial data words
module csa_buf2 (
  input wire clk_i,
  input wire rst_n_i,
  input wire [7:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  output wire [7:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);
  reg [7:0] mem_ff [0:1];
  reg wr_ptr_ff;
  reg rd_ptr_ff;
  reg [1:0] cnt_ff;
  wire push;
  wire pop;

  assign in_ready_o = (cnt_ff != 2'h2);
  assign out_valid_o = (cnt_ff != 2'h0);
  assign out_data_o = mem_ff[rd_ptr_ff];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff <= 2'h0;
      mem_ff[0] <= 8'h00;
      mem_ff[1] <= 8'h00;
    end else begin
      if (push) begin
        mem_ff[wr_ptr_ff] <= in_data_i;
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop)
        rd_ptr_ff <= ~rd_ptr_ff;
      if (push && !pop)
        cnt_ff <= cnt_ff + 2'h1;
      else if (pop && !push)
        cnt_ff <= cnt_ff - 2'h1;
    end
  end
endmodule

//--- rtl/csa_top.v
// camera serial port, camera control outputs and acquisition start
// ====================================================================
// Operation
// - one start bit, one stop bit, no parity on every character
// - no flow-control lines; characters sent without any handshake
// - two serial pairs, one each way, full duplex asynchronous
// - device drives serial-to-camera pair with its transmit data
// - bit rate selectable from 9.6 to 921.6 kbit/s, eight steps
// - software start acquires programmed frame count, then stops
// - external trigger or any trigger-bus line may start acquisition
// - each start trigger selects rising or falling edge
// - four camera-control outputs driven by device
// - control outputs can carry the exposure pulse or a software level
// - base configuration uses first connector only
// - medium/full/extended also use second connector lanes
// - front trigger line is trigger input or status output
`include "csa_defs.vh"
module csa_top (
  input wire clk_i,
  input wire rst_n_i,
  input wire [2:0] baud_sel_i,
  input wire [7:0] tx_data_i,
  input wire tx_valid_i,
  output wire tx_ready_o,
  output wire [7:0] rx_data_o,
  output wire rx_valid_o,
  input wire rx_ready_i,
  output reg rx_frame_err_o,
  output reg rx_overrun_o,
  output reg serial_to_camera_pair_o,
  input wire serial_from_camera_pair_i,
  input wire [3:0] cc_src_sel_i,
  input wire [3:0] cc_sw_level_i,
  input wire exposure_pulse_i,
  output reg [3:0] camera_control_outputs_o,
  input wire [1:0] cfg_mode_i,
  output reg port1_enable_o,
  input wire sw_start_i,
  input wire [15:0] frame_count_i,
  input wire frame_done_i,
  input wire trig_start_en_i,
  input wire [2:0] trig_src_sel_i,
  input wire trig_falling_i,
  input wire front_trig_in_i,
  input wire [`CSA_TRIG_BUS_W-1:0] system_trigger_bus_i,
  input wire front_trig_is_out_i,
  input wire front_trig_status_sel_i,
  output reg front_trig_out_o,
  output reg front_trig_oe_o,
  output reg acq_active_o,
  output reg [15:0] frames_left_o
);
  // ==================================================================
  // oversample tick divider
  reg [10:0] div_cnt_ff;
  reg tick_ff;
  function [10:0] baud_div;
    input [2:0] sel;
    reg [31:0] full;
    begin
      case (sel)
        3'h0: full = `CSA_DIV_9K6;
        3'h1: full = `CSA_DIV_19K2;
        3'h2: full = `CSA_DIV_38K4;
        3'h3: full = `CSA_DIV_57K6;
        3'h4: full = `CSA_DIV_115K2;
        3'h5: full = `CSA_DIV_230K4;
        3'h6: full = `CSA_DIV_460K8;
        default: full = `CSA_DIV_921K6;
      endcase
      // the slowest rate needs the widest divisor, and it fits eleven bits
      baud_div = full[10:0];
    end
  endfunction

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_cnt_ff <= 11'h000;
      tick_ff <= 1'b0;
    end else if (div_cnt_ff >= baud_div(baud_sel_i) - 11'h001) begin
      div_cnt_ff <= 11'h000;
      tick_ff <= 1'b1;
    end else begin
      div_cnt_ff <= div_cnt_ff + 11'h001;
      tick_ff <= 1'b0;
    end
  end

  // ==================================================================
  // transmitter: no flow control, sends whenever a word is present
  localparam TX_IDLE = 2'h0;
  localparam TX_START = 2'h1;
  localparam TX_DATA = 2'h2;
  localparam TX_STOP = 2'h3;
  reg [1:0] tx_st_ff;
  reg [3:0] tx_tick_ff;
  reg [2:0] tx_bit_ff;
  reg [7:0] tx_sh_ff;
  wire [7:0] txb_data;
  wire txb_valid;
  wire tx_take;
  assign tx_take = (tx_st_ff == TX_IDLE) && txb_valid;

  csa_buf2 u_tx_buf (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_data_i(tx_data_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .out_data_o(txb_data),
    .out_valid_o(txb_valid),
    .out_ready_i(tx_take)
  );

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_st_ff <= TX_IDLE;
      tx_tick_ff <= 4'h0;
      tx_bit_ff <= 3'h0;
      tx_sh_ff <= 8'h00;
      serial_to_camera_pair_o <= 1'b1;
    end else begin
      case (tx_st_ff)
        TX_IDLE: begin
          serial_to_camera_pair_o <= 1'b1;
          if (txb_valid) begin
            tx_sh_ff <= txb_data;
            tx_tick_ff <= 4'h0;
            tx_st_ff <= TX_START;
            serial_to_camera_pair_o <= 1'b0;
          end
        end
        TX_START: if (tick_ff) begin
          if (tx_tick_ff == `CSA_LAST_TICK) begin
            tx_st_ff <= TX_DATA;
            tx_bit_ff <= 3'h0;
            serial_to_camera_pair_o <= tx_sh_ff[0];
          end
          tx_tick_ff <= tx_tick_ff + 4'h1;
        end
        TX_DATA: if (tick_ff) begin
          if (tx_tick_ff == `CSA_LAST_TICK) begin
            if (tx_bit_ff == 3'h7) begin
              tx_st_ff <= TX_STOP;
              serial_to_camera_pair_o <= 1'b1;
            end else begin
              tx_bit_ff <= tx_bit_ff + 3'h1;
              serial_to_camera_pair_o <= tx_sh_ff[tx_bit_ff + 3'h1];
            end
          end
          tx_tick_ff <= tx_tick_ff + 4'h1;
        end
        TX_STOP: if (tick_ff) begin
          if (tx_tick_ff == `CSA_LAST_TICK)
            tx_st_ff <= TX_IDLE;
          tx_tick_ff <= tx_tick_ff + 4'h1;
        end
        default: tx_st_ff <= TX_IDLE;
      endcase
    end
  end

  // ==================================================================
  // receiver: 16x oversampling, sample at tick 7 of each bit
  reg rx_s1_ff;
  reg rx_s2_ff;
  reg [1:0] rx_st_ff;
  reg [3:0] rx_tick_ff;
  reg [2:0] rx_bit_ff;
  reg [7:0] rx_sh_ff;
  reg rx_push_ff;
  wire rxb_ready;

  csa_buf2 u_rx_buf (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_data_i(rx_sh_ff),
    .in_valid_i(rx_push_ff),
    .in_ready_o(rxb_ready),
    .out_data_o(rx_data_o),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i)
  );

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
      rx_st_ff <= TX_IDLE;
      rx_tick_ff <= 4'h0;
      rx_bit_ff <= 3'h0;
      rx_sh_ff <= 8'h00;
      rx_push_ff <= 1'b0;
      rx_frame_err_o <= 1'b0;
      rx_overrun_o <= 1'b0;
    end else begin
      // line comes from the camera with its own timing
      rx_s1_ff <= serial_from_camera_pair_i;
      rx_s2_ff <= rx_s1_ff;
      rx_push_ff <= 1'b0;
      if (rx_push_ff && !rxb_ready)
        rx_overrun_o <= 1'b1;
      case (rx_st_ff)
        TX_IDLE: if (!rx_s2_ff) begin
          rx_tick_ff <= 4'h0;
          rx_st_ff <= TX_START;
        end
        TX_START: if (tick_ff) begin
          if (rx_tick_ff == `CSA_MID_TICK) begin
            // a glitch shorter than half a bit is not a start
            if (rx_s2_ff)
              rx_st_ff <= TX_IDLE;
            else begin
              rx_st_ff <= TX_DATA;
              rx_bit_ff <= 3'h0;
            end
            rx_tick_ff <= 4'h0;
          end else
            rx_tick_ff <= rx_tick_ff + 4'h1;
        end
        TX_DATA: if (tick_ff) begin
          if (rx_tick_ff == `CSA_LAST_TICK) begin
            rx_sh_ff <= {rx_s2_ff, rx_sh_ff[7:1]};
            if (rx_bit_ff == 3'h7)
              rx_st_ff <= TX_STOP;
            rx_bit_ff <= rx_bit_ff + 3'h1;
          end
          rx_tick_ff <= rx_tick_ff + 4'h1;
        end
        TX_STOP: if (tick_ff) begin
          if (rx_tick_ff == `CSA_LAST_TICK) begin
            rx_frame_err_o <= !rx_s2_ff;
            rx_push_ff <= rx_s2_ff;
            rx_st_ff <= TX_IDLE;
          end
          rx_tick_ff <= rx_tick_ff + 4'h1;
        end
        default: rx_st_ff <= TX_IDLE;
      endcase
    end
  end

  // ==================================================================
  // acquisition start
  reg trig_prev_ff;
  reg [2:0] last_src_ff;
  reg trig_sel;
  always @* begin
    if (trig_src_sel_i == `CSA_SRC_EXT)
      trig_sel = front_trig_in_i && !front_trig_is_out_i;
    else
      trig_sel = system_trigger_bus_i[trig_src_sel_i - 3'h1];
  end
  wire trig_edge;
  // edge only counts if the source did not just change
  assign trig_edge = (last_src_ff == trig_src_sel_i) &&
                     (trig_falling_i ? (trig_prev_ff && !trig_sel)
                                     : (!trig_prev_ff && trig_sel));

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      // follow the line's level so leaving reset makes no false edge
      trig_prev_ff <= trig_sel;
      last_src_ff <= 3'h0;
      acq_active_o <= 1'b0;
      frames_left_o <= 16'h0000;
    end else begin
      trig_prev_ff <= trig_sel;
      last_src_ff <= trig_src_sel_i;
      if (!acq_active_o) begin
        // a zero count is ignored: at least one frame
        if ((sw_start_i || (trig_start_en_i && trig_edge)) &&
            frame_count_i != 16'h0000) begin
          acq_active_o <= 1'b1;
          frames_left_o <= frame_count_i;
        end
      end else if (frame_done_i) begin
        frames_left_o <= frames_left_o - 16'h0001;
        if (frames_left_o == 16'h0001)
          acq_active_o <= 1'b0;
      end
    end
  end

  // ==================================================================
  // camera control, connector use and front trigger output
  integer i;
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      camera_control_outputs_o <= 4'h0;
      port1_enable_o <= 1'b0;
      front_trig_out_o <= 1'b0;
      front_trig_oe_o <= 1'b0;
    end else begin
      for (i = 0; i < 4; i = i + 1)
        camera_control_outputs_o[i] <= cc_src_sel_i[i] ?
          exposure_pulse_i : cc_sw_level_i[i];
      port1_enable_o <= (cfg_mode_i != 2'h0);
      front_trig_oe_o <= front_trig_is_out_i;
      front_trig_out_o <= front_trig_is_out_i &&
        (front_trig_status_sel_i ? acq_active_o : rx_frame_err_o);
    end
  end
endmodule

//--- verification/csa_top_props.sv
// concurrent checks on the camera serial and acquisition block ports
module csa_top_props (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] cfg_mode_i,
  input wire logic port1_enable_o,
  input wire logic [3:0] cc_src_sel_i,
  input wire logic [3:0] cc_sw_level_i,
  input wire logic exposure_pulse_i,
  input wire logic [3:0] camera_control_outputs_o,
  input wire logic sw_start_i,
  input wire logic [15:0] frame_count_i,
  input wire logic frame_done_i,
  input wire logic acq_active_o,
  input wire logic [15:0] frames_left_o,
  input wire logic [7:0] rx_data_o,
  input wire logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire logic rx_overrun_o,
  input wire logic serial_to_camera_pair_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==================================================================
  // properties
  property p_port1;
    $past(rst_n_i) |-> port1_enable_o == ($past(cfg_mode_i) != 2'h0);
  endproperty
  a_port1: assert property (p_port1) else $error("port1 wrong");
  property p_cc;
    $past(rst_n_i) |-> camera_control_outputs_o ==
      (($past(cc_src_sel_i) & {4{$past(exposure_pulse_i)}}) |
      (~$past(cc_src_sel_i) & $past(cc_sw_level_i)));
  endproperty
  a_cc: assert property (p_cc) else $error("control out wrong");
  property p_start;
    !acq_active_o && sw_start_i && frame_count_i != 16'h0 |=>
      acq_active_o && frames_left_o == $past(frame_count_i);
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_dec;
    acq_active_o && frame_done_i && frames_left_o > 16'h1 |=>
      acq_active_o && frames_left_o == $past(frames_left_o) - 16'h1;
  endproperty
  a_dec: assert property (p_dec) else $error("bad count");
  property p_stop;
    acq_active_o && frame_done_i && frames_left_o == 16'h1 |=>
      !acq_active_o && frames_left_o == 16'h0;
  endproperty
  a_stop: assert property (p_stop) else $error("no stop");
  property p_hold;
    rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o);
  endproperty
  a_hold: assert property (p_hold) else $error("rx word lost");
  property p_ovr;
    rx_overrun_o |=> rx_overrun_o;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun cleared");
  property p_sbit;
    $fell(serial_to_camera_pair_o) |-> !serial_to_camera_pair_o [*8];
  endproperty
  a_sbit: assert property (p_sbit) else $error("short start");
  property p_rst;
    @(posedge clk_i) disable iff (1'b0)
      !rst_n_i |=> serial_to_camera_pair_o && !acq_active_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  c_start: cover property (!acq_active_o && sw_start_i ##1 acq_active_o);
  c_ovr: cover property ($rose(rx_overrun_o));
  c_stall: cover property (rx_valid_o && !rx_ready_i [*2]);
endmodule
bind csa_top csa_top_props u_props (.clk_i, .rst_n_i, .cfg_mode_i,
  .port1_enable_o, .cc_src_sel_i, .cc_sw_level_i, .exposure_pulse_i,
  .camera_control_outputs_o, .sw_start_i, .frame_count_i, .frame_done_i,
  .acq_active_o, .frames_left_o, .rx_data_o, .rx_valid_o, .rx_ready_i,
  .rx_overrun_o, .serial_to_camera_pair_o);

//--- verification/csa_cam_model.sv
// camera stand-in: sends characters and decodes the device's line
module csa_cam_model (
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int bit_cyc = 208;
  logic [8:0] r;
  logic [8:0] got_q[$];
  initial line_o = 1'b1;
  // ==================================================================
  // no handshake: a character goes out as soon as it is asked for
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_o <= f[i];
      // a low stop bit is cut to three quarters, so its tail is too short
      // to be taken for the start of another character
      if (i == 9 && !stop)
        repeat (bit_cyc * 3 / 4) @(posedge clk_i);
      else
        repeat (bit_cyc) @(posedge clk_i);
    end
    line_o <= 1'b1;
    // one idle clock keeps the next start apart from this stop
    @(posedge clk_i);
  endtask
  // stop bit kept with the data so a bad frame shows in the compare
  initial forever begin
    @(negedge line_i);
    repeat (bit_cyc / 2) @(posedge clk_i);
    for (int i = 0; i < 9; i++) begin
      repeat (bit_cyc) @(posedge clk_i);
      r[i] = line_i;
    end
    got_q.push_back(r);
  end
endmodule

//--- verification/camera_serial_and_acq_start_tb.sv
// self-checking bench for the camera serial and acquisition block
`include "csa_defs.vh"
module camera_serial_and_acq_start_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_n_i = 1'b0, tx_valid_i = 1'b0, rx_ready_i = 1'b0;
  logic sw_start_i = 1'b0, frame_done_i = 1'b0, trig_start_en_i = 1'b0;
  logic trig_falling_i = 1'b0, front_trig_in_i = 1'b0, exposure_pulse_i;
  logic front_trig_is_out_i = 1'b0, front_trig_status_sel_i = 1'b0;
  logic [2:0] baud_sel_i = 3'h7, trig_src_sel_i = 3'h0;
  logic [7:0] tx_data_i = 8'h00, seed = 8'h34, rnd = 8'h34;
  logic [3:0] cc_src_sel_i, cc_sw_level_i, camera_control_outputs_o;
  logic [1:0] cfg_mode_i;
  logic [15:0] frame_count_i = 16'h0000, frames_left_o;
  logic [`CSA_TRIG_BUS_W-1:0] system_trigger_bus_i = '0;
  logic [7:0] rx_data_o;
  logic tx_ready_o, rx_valid_o, rx_frame_err_o, rx_overrun_o;
  logic serial_to_camera_pair_o, serial_from_camera_pair_i;
  logic port1_enable_o, front_trig_out_o, front_trig_oe_o, acq_active_o;
  int errors = 0, n_compared = 0;
  initial {cfg_mode_i, cc_src_sel_i, cc_sw_level_i, exposure_pulse_i} = '0;
  always #2.5 clk_i = ~clk_i;
  csa_top dut (.clk_i, .rst_n_i, .baud_sel_i, .tx_data_i, .tx_valid_i,
    .tx_ready_o, .rx_data_o, .rx_valid_o, .rx_ready_i, .rx_frame_err_o,
    .rx_overrun_o, .serial_to_camera_pair_o, .serial_from_camera_pair_i,
    .cc_src_sel_i, .cc_sw_level_i, .exposure_pulse_i,
    .camera_control_outputs_o, .cfg_mode_i, .port1_enable_o, .sw_start_i,
    .frame_count_i, .frame_done_i, .trig_start_en_i, .trig_src_sel_i,
    .trig_falling_i, .front_trig_in_i, .system_trigger_bus_i,
    .front_trig_is_out_i, .front_trig_status_sel_i, .front_trig_out_o,
    .front_trig_oe_o, .acq_active_o, .frames_left_o);
  csa_cam_model m (.clk_i, .line_i(serial_to_camera_pair_o),
    .line_o(serial_from_camera_pair_i));
  // ==================================================================
  // helpers
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %h, expected %h", $time, got, exp);
    end
  endtask
  // valid stays up on return so back-to-back words need no gap
  task automatic put(input logic [7:0] d);
    tx_data_i <= d;
    tx_valid_i <= 1'b1;
    @(negedge clk_i);
    while (!tx_ready_o) @(negedge clk_i);
    @(posedge clk_i);
  endtask
  task automatic pulse(input int s, input logic v);
    @(posedge clk_i);
    if (s == 0) front_trig_in_i <= v;
    else system_trigger_bus_i[s - 1] <= v;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic wrap_up;
    $display("errors %0d, compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    rnd <= lfsr(rnd);
    {cfg_mode_i, cc_src_sel_i, cc_sw_level_i, exposure_pulse_i} <=
      {rnd, rnd[2:0]};
  end
  // the scenarios need about 41000 clocks; the limit leaves a wide margin
  initial begin
    repeat (60000) @(posedge clk_i);
    errors++;
    wrap_up();
  end
  // ==================================================================
  // scenarios
  initial begin
    logic [7:0] d[3];
    int n;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    cmp({serial_to_camera_pair_o, tx_ready_o, acq_active_o}, 3'h6);
    for (int s = 7; s >= 6; s--) begin
      @(posedge clk_i);
      baud_sel_i <= 3'(s);
      m.bit_cyc = 16 * (200000000 / ((115200 << (s - 4)) * 16));
      d = '{8'h00, 8'hFF, seed};
      seed = lfsr(seed);
      foreach (d[k]) put(d[k]);
      tx_valid_i <= 1'b0;
      @(negedge clk_i);
      cmp(tx_ready_o, 1'b0);
      wait (m.got_q.size() == 3);
      foreach (d[k]) cmp(m.got_q.pop_front(), {1'b1, d[k]});
    end
    for (int k = 0; k < 3; k++) begin
      d[k] = seed;
      seed = lfsr(seed);
      m.send(d[k], 1'b1);
    end
    m.send(8'hA5, 1'b0);
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    cmp({rx_overrun_o, rx_frame_err_o}, 2'h3);
    for (int k = 0; k < 2; k++) begin
      cmp({rx_valid_o, rx_data_o}, {1'b1, d[k]});
      @(posedge clk_i) rx_ready_i <= 1'b1;
      @(posedge clk_i) rx_ready_i <= 1'b0;
      @(negedge clk_i);
    end
    cmp(rx_valid_o, 1'b0);
    m.send(seed, 1'b1);
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    cmp({rx_frame_err_o, rx_valid_o, rx_data_o}, {2'b01, seed});
    for (int j = 0; j < 3; j++) begin
      @(posedge clk_i);
      front_trig_is_out_i <= 1'b1;
      front_trig_status_sel_i <= 1'b1;
      n = (j == 2) ? seed[2:0] + 2 : j;
      frame_count_i <= 16'(n);
      sw_start_i <= 1'b1;
      @(posedge clk_i) sw_start_i <= 1'b0;
      @(negedge clk_i);
      cmp({acq_active_o, frames_left_o}, {n != 0, 16'(n)});
      @(negedge clk_i);
      cmp({front_trig_oe_o, front_trig_out_o}, {1'b1, n != 0});
      repeat (n) begin
        @(posedge clk_i) frame_done_i <= 1'b1;
        @(posedge clk_i) frame_done_i <= 1'b0;
      end
      @(negedge clk_i);
      cmp({acq_active_o, frames_left_o}, 17'h0);
    end
    @(posedge clk_i) front_trig_is_out_i <= 1'b0;
    frame_count_i <= 16'h0001;
    for (int f = 0; f < 2; f++) begin
      @(posedge clk_i) trig_start_en_i <= 1'b0;
      trig_falling_i <= f[0];
      front_trig_in_i <= f[0];
      system_trigger_bus_i <= {`CSA_TRIG_BUS_W{f[0]}};
      repeat (3) @(posedge clk_i);
      trig_start_en_i <= 1'b1;
      for (int s = 0; s < 8; s++) begin
        @(posedge clk_i) trig_src_sel_i <= 3'(s);
        repeat (3) @(posedge clk_i);
        pulse(s, !f[0]);
        cmp(acq_active_o, 1'b1);
        @(posedge clk_i) frame_done_i <= 1'b1;
        @(posedge clk_i) frame_done_i <= 1'b0;
        pulse(s, f[0]);
        cmp(acq_active_o, 1'b0);
      end
    end
    wrap_up();
  end
endmodule
